// >>> pts_pkg.sv
// Shared constants, types and helpers of the programmable threshold stage
package pts_pkg;

  // Channel count and value width (0.0001 per LSB)
  localparam int NCH = 3;
  localparam int VW  = 40;

  typedef logic signed [VW-1:0] pts_val_t;
  typedef logic signed [31:0]   pts_word_t;

  // Comparator modes, in register encoding order
  typedef enum logic [2:0] {
    MD_OVER, MD_OVER_ABS, MD_UNDER, MD_UNDER_ABS,
    MD_DREL_DIR, MD_DREL_ABS, MD_DVAL_DIR, MD_DVAL_ABS
  } pts_mode_t;

  // Stage condition
  typedef enum logic [1:0] {
    ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED
  } pts_cond_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pts_req_t;

  // Per comparator settings
  typedef struct packed {
    pts_mode_t   mode;
    logic signed [31:0] mult;
    pts_val_t    pick;
    logic [19:0] hyst;
    pts_val_t    blim;
  } pts_chcfg_t;

  // Whole state of the stage
  typedef struct packed {
    pts_chcfg_t [NCH-1:0] cfg;
    pts_val_t [NCH-1:0]   old;
    logic [NCH-1:0]       ful;
    logic                 wok;
    logic [19:0]          wpre;
    logic [3:0][31:0]     ratio;
    logic [1:0]           num;
    logic [18:0]          opdly;
    logic [18:0]          reldly;
    pts_cond_t            cond;
    logic [19:0]          opre;
    logic [19:0]          rpre;
    logic [18:0]          ocnt;
    logic [18:0]          rcnt;
    logic [31:0]          remain;
    logic [1:0]           dch;
    logic [5:0]           dcnt;
    logic [55:0]          dsh;
    logic [40:0]          drem;
    logic                 dneg;
    logic [31:0]          rdata;
  } pts_state_t;

  // Register offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_OPDLY  = 8'h04;
  localparam logic [7:0] A_RELDLY = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0C;
  localparam logic [7:0] A_EXPECT = 8'h10;
  localparam logic [7:0] A_REMAIN = 8'h14;
  localparam logic [7:0] A_CRATIO = 8'h18;
  localparam logic [2:0] CH_BASE  = 3'h2;
  localparam logic [2:0] CH_LAST  = 3'h4;
  // Channel field word indices
  localparam logic [2:0] F_MODE   = 3'h0;
  localparam logic [2:0] F_MULT   = 3'h1;
  localparam logic [2:0] F_PLO    = 3'h2;
  localparam logic [2:0] F_PHI    = 3'h3;
  localparam logic [2:0] F_HYST   = 3'h4;
  localparam logic [2:0] F_BLIM   = 3'h5;
  localparam logic [2:0] F_SCALED = 3'h6;
  localparam logic [2:0] F_RATIO  = 3'h7;

  // Reset values and write limits
  localparam logic [1:0]  NUM_RST    = 2'h1;
  localparam logic [31:0] MULT_RST   = 32'h0001_0000;
  localparam pts_val_t    PICK_RST   = 40'h00_0000_0064;
  localparam logic [19:0] HYST_RST   = 20'h0_7530;
  localparam logic [19:0] HYST_MAX   = 20'h7_A120;
  localparam logic [18:0] OPDLY_RST  = 19'h0_0008;
  localparam logic [18:0] RELDLY_RST = 19'h0_000C;
  localparam logic [18:0] DLY_MAX    = 19'h5_7E40;

  // Fixed point scales
  localparam logic [19:0]        PPM       = 20'hF_4240;
  localparam logic signed [95:0] PPM_W     = 96'sh0F_4240;
  localparam logic [55:0]        RATIO_ONE = 56'h00_2710;
  localparam logic [31:0]        STEP_MS   = 32'h0000_0005;
  localparam logic [5:0]         DIV_END   = 6'h39;

  // Timing
  localparam int CLK_MHZ  = 50;
  localparam int STEP_US  = 5000;
  localparam int WIN_US   = 20000;
  localparam int STEP_CYC = STEP_US * CLK_MHZ;
  localparam int WIN_CYC  = WIN_US * CLK_MHZ;

  // Magnitude of a signed value
  function automatic pts_val_t pts_abs(input pts_val_t a);
    return a[VW-1] ? -a : a;
  endfunction

endpackage

// >>> pts_stage.sv
// Programmable threshold stage with three comparators and delays
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps

module pts_stage
  import pts_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC,
  parameter int WIN_CYCLES  = WIN_CYC
) (
  input  wire logic                 CLK_IN,
  input  wire logic                 NRST_IN,
  input  wire pts_req_t             BUS_IN,
  output logic [31:0]               RDATA_OUT,
  input  wire pts_word_t [NCH-1:0]  MEAS_IN,
  input  wire pts_word_t            CALC_IN,
  input  wire logic                 BLOCK_IN,
  output pts_cond_t                 COND_OUT,
  output logic                      START_OUT,
  output logic                      TRIP_OUT,
  output logic                      BLOCKED_OUT
);

  // One register holds the whole stage; s_d is its next value
  // Settings, timers, divider and read data all live in this struct
  pts_state_t s_q;
  pts_state_t s_d;

  // Values fed to the ratio divider, entry 3 is the calculated value
  // Entries 0 to 2 are the scaled channels
  pts_val_t   rv [4];
  pts_val_t   dp [4];
  logic [NCH-1:0] ful_d;

  assign rv[3] = {{(VW-32){CALC_IN[31]}}, CALC_IN};
  assign dp[3] = s_q.cfg[0].pick;

  // Per comparator scaling and comparison
  // One copy per channel; inactive channels never set their flag
  // Change modes compare against the last 20 ms snapshot
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic signed [63:0] prod;
    logic [59:0]        hp;
    logic [59:0]        hq;
    pts_val_t           v;
    pts_val_t           d;
    pts_val_t           ap;
    pts_val_t           h;
    pts_val_t           x;
    pts_val_t           t;
    pts_val_t           thr;
    logic signed [95:0] lhs;
    logic signed [95:0] rhs;
    logic               rel;
    logic               dlt;
    logic               blk;

    // Multiplier is signed Q16.16, so the product drops 16 fraction bits
    // Scaled value keeps 40 bits, enough for the full pick-up range
    // Overflow beyond 40 bits wraps; keep multipliers within range
    assign prod = MEAS_IN[i] * s_q.cfg[i].mult;
    assign v    = prod[VW+15:16];
    assign d    = v - s_q.old[i];
    assign ap   = pts_abs(s_q.cfg[i].pick);
    assign hp   = ap * s_q.cfg[i].hyst;
    assign hq   = hp / PPM;
    assign h    = hq[VW-1:0];
    assign rv[i] = v;
    assign dp[i] = s_q.cfg[i].pick;

    // Mode selects metric, threshold and gating
    // Every mode reduces to one test: metric above threshold
    // Directional change modes follow the sign of the pick-up
    always_comb begin
      x   = v;
      t   = s_q.cfg[i].pick;
      rel = 1'b0;
      dlt = 1'b0;
      blk = 1'b0;
      unique case (s_q.cfg[i].mode)
        MD_OVER: begin
          x = v;
        end
        MD_OVER_ABS: begin
          x = pts_abs(v);
        end
        MD_UNDER: begin
          x   = -v;
          t   = -s_q.cfg[i].pick;
          blk = v < s_q.cfg[i].blim;
        end
        MD_UNDER_ABS: begin
          x   = -pts_abs(v);
          t   = -s_q.cfg[i].pick;
          blk = v < s_q.cfg[i].blim;
        end
        MD_DREL_DIR: begin
          x   = s_q.cfg[i].pick[VW-1] ? -d : d;
          t   = ap;
          rel = 1'b1;
          dlt = 1'b1;
        end
        MD_DREL_ABS: begin
          x   = pts_abs(d);
          t   = ap;
          rel = 1'b1;
          dlt = 1'b1;
        end
        MD_DVAL_DIR: begin
          x   = s_q.cfg[i].pick[VW-1] ? -d : d;
          t   = ap;
          dlt = 1'b1;
        end
        MD_DVAL_ABS: begin
          x   = pts_abs(d);
          t   = ap;
          dlt = 1'b1;
        end
      endcase
    end

    // Threshold drops by the hysteresis once fulfilled
    // Under modes negate both sides, so lowering the threshold here
    // raises the release level above the pick-up
    // Relative modes compare delta times one million against
    // pick-up times the snapshot magnitude, avoiding a divider
    assign thr = s_q.ful[i] ? t - h : t;
    assign lhs = rel ? 96'(x) * PPM_W : 96'(x);
    assign rhs = rel ? 96'(thr) * 96'(pts_abs(s_q.old[i]))
                     : 96'(thr);
    assign ful_d[i] = (2'(i) < s_q.num) && !blk
                    && !(dlt && !s_q.wok) && (lhs > rhs);
  end

  // Divider step terms
  // Restoring division, one quotient bit per clock, 56 steps a ratio
  // Quotient above 31 bits saturates to the largest positive value
  // A zero pick-up gives all ones, which saturates the same way
  // Sign of the result is the sign of value times sign of pick-up
  logic [40:0] dr;
  logic        dge;
  pts_val_t    dad;
  logic [31:0] dmag;
  logic        pick;

  assign dad  = pts_abs(dp[s_q.dch]);
  assign dr   = {s_q.drem[39:0], s_q.dsh[55]};
  assign dge  = dr >= {1'b0, dad};
  assign dmag = |s_q.dsh[55:31] ? 32'h7FFF_FFFF : s_q.dsh[31:0];
  assign pick = |s_q.ful;

  // Bus decode
  // Channel windows start at 0x40, 0x20 bytes apart, eight words each
  // Word index within a window selects the channel field
  // Unmapped addresses read as zero and ignore writes
  logic       is_ch;
  logic [1:0] ch;
  logic [2:0] fld;

  assign is_ch = (BUS_IN.addr[7:5] >= CH_BASE)
               && (BUS_IN.addr[7:5] <= CH_LAST);
  assign ch    = 2'(BUS_IN.addr[7:5] - CH_BASE);
  assign fld   = BUS_IN.addr[4:2];

  // Next state of the whole stage
  // One process computes every field of the next state
  // Later sections may override earlier ones within a cycle
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.ful   = ful_d;

    // 20 ms snapshot for the change modes
    // Change modes stay blind until the first snapshot is valid
    // A step right before a snapshot is still seen for one cycle
    if (s_d.wpre == 20'(WIN_CYCLES - 1)) begin
      s_d.wpre = 20'h0_0000;
      s_d.wok  = 1'b1;
      for (int k = 0; k < NCH; k++) begin
        s_d.old[k] = rv[k];
      end
    end else begin
      s_d.wpre = s_q.wpre + 20'h0_0001;
    end

    // Ratio divider cycles over the four ratios
    // Order is channel 0, 1, 2 then the calculated value
    // Each ratio takes 58 clocks, so each one refreshes every 232 clocks
    if (s_q.dcnt == 6'h00) begin
      s_d.dsh  = 56'(pts_abs(rv[s_q.dch])) * RATIO_ONE;
      s_d.drem = 41'h0;
      s_d.dneg = rv[s_q.dch][VW-1] ^ dp[s_q.dch][VW-1];
      s_d.dcnt = 6'h01;
    end else if (s_q.dcnt == DIV_END) begin
      s_d.ratio[s_q.dch] = s_q.dneg ? -dmag : dmag;
      s_d.dch  = s_q.dch + 2'h1;
      s_d.dcnt = 6'h00;
    end else begin
      s_d.drem = dge ? dr - {1'b0, dad} : dr;
      s_d.dsh  = {s_q.dsh[54:0], dge};
      s_d.dcnt = s_q.dcnt + 6'h01;
    end

    // Condition sequencing
    // Operating timer runs only while picked up in start
    // During release it freezes and resumes if pick-up returns
    // Operating timer restarts only from the normal state; release timer also clears whenever pick-up returns
    // Blocking in start or trip aborts the event at once
    unique case (s_q.cond)
      ST_NORMAL: begin
        if (pick) begin
          s_d.cond = BLOCK_IN ? ST_BLOCKED : ST_START;
          s_d.opre = 20'h0_0000;
          s_d.ocnt = 19'h0_0000;
          s_d.rpre = 20'h0_0000;
          s_d.rcnt = 19'h0_0000;
        end
      end
      ST_BLOCKED: begin
        if (!pick || !BLOCK_IN) begin
          s_d.cond = ST_NORMAL;
        end
      end
      ST_START, ST_TRIP: begin
        if (BLOCK_IN) begin
          s_d.cond = ST_BLOCKED;
        end else if (pick) begin
          s_d.rpre = 20'h0_0000;
          s_d.rcnt = 19'h0_0000;
          if (s_q.cond == ST_START) begin
            if (s_q.ocnt >= s_q.opdly) begin
              s_d.cond = ST_TRIP;
            end else if (s_q.opre == 20'(STEP_CYCLES - 1)) begin
              s_d.opre = 20'h0_0000;
              s_d.ocnt = s_q.ocnt + 19'h0_0001;
            end else begin
              s_d.opre = s_q.opre + 20'h0_0001;
            end
          end
        end else begin
          if (s_q.rcnt >= s_q.reldly) begin
            s_d.cond = ST_NORMAL;
          end else if (s_q.rpre == 20'(STEP_CYCLES - 1)) begin
            s_d.rpre = 20'h0_0000;
            s_d.rcnt = s_q.rcnt + 19'h0_0001;
          end else begin
            s_d.rpre = s_q.rpre + 20'h0_0001;
          end
        end
      end
    endcase

    // Time left before trip in ms
    // Shown in 5 ms steps, one clock behind the timer
    // Reads zero outside the start state
    if (s_q.cond == ST_START && s_q.ocnt < s_q.opdly) begin
      s_d.remain = 32'(s_q.opdly - s_q.ocnt) * STEP_MS;
    end else begin
      s_d.remain = 32'h0000_0000;
    end

    // Register writes
    // Delays and hysteresis clamp to their maximum
    // A comparator count of zero is taken as one
    // Read-only words ignore writes
    if (BUS_IN.wr) begin
      if (is_ch) begin
        unique case (fld)
          F_MODE: s_d.cfg[ch].mode = pts_mode_t'(BUS_IN.wdata[2:0]);
          F_MULT: s_d.cfg[ch].mult = BUS_IN.wdata;
          F_PLO:  s_d.cfg[ch].pick[31:0] = BUS_IN.wdata;
          F_PHI:  s_d.cfg[ch].pick[VW-1:32] = BUS_IN.wdata[7:0];
          F_HYST: s_d.cfg[ch].hyst =
            (BUS_IN.wdata[19:0] > HYST_MAX || |BUS_IN.wdata[31:20])
              ? HYST_MAX : BUS_IN.wdata[19:0];
          F_BLIM: s_d.cfg[ch].blim =
            {{(VW-32){BUS_IN.wdata[31]}}, BUS_IN.wdata};
          default: ;
        endcase
      end else if (BUS_IN.addr == A_CTRL) begin
        s_d.num = (BUS_IN.wdata[1:0] == 2'h0) ? 2'h1
                                               : BUS_IN.wdata[1:0];
      end else if (BUS_IN.addr == A_OPDLY) begin
        s_d.opdly = (BUS_IN.wdata > 32'(DLY_MAX))
                    ? DLY_MAX : BUS_IN.wdata[18:0];
      end else if (BUS_IN.addr == A_RELDLY) begin
        s_d.reldly = (BUS_IN.wdata > 32'(DLY_MAX))
                     ? DLY_MAX : BUS_IN.wdata[18:0];
      end
    end

    // Register reads, answered in the next cycle
    // Read data stands for one cycle only, zero otherwise
    // Status packs condition, fulfilled flags and window valid
    if (BUS_IN.rd) begin
      if (is_ch) begin
        unique case (fld)
          F_MODE:   s_d.rdata = 32'(s_q.cfg[ch].mode);
          F_MULT:   s_d.rdata = s_q.cfg[ch].mult;
          F_PLO:    s_d.rdata = s_q.cfg[ch].pick[31:0];
          F_PHI:    s_d.rdata = 32'(s_q.cfg[ch].pick[VW-1:32]);
          F_HYST:   s_d.rdata = 32'(s_q.cfg[ch].hyst);
          F_BLIM:   s_d.rdata = s_q.cfg[ch].blim[31:0];
          F_SCALED: s_d.rdata = rv[ch][31:0];
          F_RATIO:  s_d.rdata = s_q.ratio[ch];
        endcase
      end else begin
        unique case (BUS_IN.addr)
          A_CTRL:   s_d.rdata = 32'(s_q.num);
          A_OPDLY:  s_d.rdata = 32'(s_q.opdly);
          A_RELDLY: s_d.rdata = 32'(s_q.reldly);
          A_STAT:   s_d.rdata = 32'({s_q.wok, s_q.ful, s_q.cond});
          A_EXPECT: s_d.rdata = 32'(s_q.opdly) * STEP_MS;
          A_REMAIN: s_d.rdata = s_q.remain;
          A_CRATIO: s_d.rdata = s_q.ratio[3];
          default:  s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register with synchronous reset
  // Reset clears every field, then loads the default settings
  // Timers, snapshot and ratios start from zero
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      s_q        <= '0;
      s_q.num    <= NUM_RST;
      s_q.opdly  <= OPDLY_RST;
      s_q.reldly <= RELDLY_RST;
      for (int k = 0; k < NCH; k++) begin
        s_q.cfg[k].mode <= MD_OVER;
        s_q.cfg[k].mult <= MULT_RST;
        s_q.cfg[k].pick <= PICK_RST;
        s_q.cfg[k].hyst <= HYST_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs decoded from the condition register
  // Start stays high through trip, as trip follows a start
  // All flags come straight from the registered condition
  assign RDATA_OUT   = s_q.rdata;
  assign COND_OUT    = s_q.cond;
  assign START_OUT   = (s_q.cond == ST_START) || (s_q.cond == ST_TRIP);
  assign TRIP_OUT    = s_q.cond == ST_TRIP;
  assign BLOCKED_OUT = s_q.cond == ST_BLOCKED;

endmodule

// >>> pts_stage_props.sv
// Port assertions of the threshold stage
`timescale 1ns/1ps
module pts_stage_props
  import pts_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        NRST_IN,
  input wire pts_req_t    BUS_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        BLOCK_IN,
  input wire pts_cond_t   COND_OUT,
  input wire logic        START_OUT,
  input wire logic        TRIP_OUT,
  input wire logic        BLOCKED_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  // Output flags follow the condition code
  property p_dec;
    START_OUT == (COND_OUT inside {ST_START, ST_TRIP});
  endproperty
  a_dec: assert property (p_dec)
    else $error("start flag wrong");
  property p_dec2;
    TRIP_OUT == (COND_OUT == ST_TRIP) &&
      BLOCKED_OUT == (COND_OUT == ST_BLOCKED);
  endproperty
  a_dec2: assert property (p_dec2)
    else $error("trip or blocked flag wrong");
  // Reset gives normal state and quiet read data
  property p_rst;
    disable iff (1'b0)
    !NRST_IN |=> COND_OUT == ST_NORMAL && !START_OUT && RDATA_OUT == 32'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("not idle after reset");
  // Read data only in the cycle after a read
  property p_rd;
    !BUS_IN.rd |=> RDATA_OUT == 32'h0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data without read");
  // Trip only out of start
  property p_trip;
    $rose(TRIP_OUT) |-> $past(COND_OUT) == ST_START;
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip not from start");
  property p_norm;
    COND_OUT == ST_NORMAL |=> COND_OUT != ST_TRIP;
  endproperty
  a_norm: assert property (p_norm)
    else $error("normal jumped to trip");
  // Blocked needs the blocking input, and the input blocks a start or trip
  property p_bcause;
    $rose(BLOCKED_OUT) |-> $past(BLOCK_IN) || $past(BLOCK_IN, 2);
  endproperty
  a_bcause: assert property (p_bcause)
    else $error("blocked without block");
  property p_benter;
    BLOCK_IN && START_OUT |-> ##[1:2] BLOCKED_OUT;
  endproperty
  a_benter: assert property (p_benter)
    else $error("start not blocked");
endmodule

bind pts_stage pts_stage_props pts_stage_props_inst (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .BUS_IN(BUS_IN),
  .RDATA_OUT(RDATA_OUT), .BLOCK_IN(BLOCK_IN), .COND_OUT(COND_OUT),
  .START_OUT(START_OUT), .TRIP_OUT(TRIP_OUT), .BLOCKED_OUT(BLOCKED_OUT)
);

// >>> pts_meas_src.sv
// Measurement source model feeding values to the stage
`timescale 1ns/1ps
module pts_meas_src
  import pts_pkg::*;
(
  input  wire logic                clk_in,
  input  wire pts_word_t [NCH-1:0] meas_req_in,
  input  wire pts_word_t           calc_req_in,
  output pts_word_t [NCH-1:0]      meas_out,
  output pts_word_t                calc_out
);
  pts_word_t [NCH-1:0] meas_q = '0;
  pts_word_t           calc_q = '0;
  // New samples show one cycle after request
  always @(posedge clk_in) begin
    meas_q <= meas_req_in;
    calc_q <= calc_req_in;
  end
  assign meas_out = meas_q;
  assign calc_out = calc_q;
endmodule

// >>> pts_stage_tb_top.sv
// Self-checking bench of the threshold stage
`timescale 1ns/1ps
module pts_stage_tb_top
  import pts_pkg::*;
;
  localparam int SC  = 10;
  localparam int OPS = 8;
  localparam int RLS = 12;
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  pts_req_t            req = '0;
  logic [31:0]         rdata;
  pts_word_t [NCH-1:0] mreq = '0;
  pts_word_t [NCH-1:0] meas;
  pts_word_t           creq = '0;
  pts_word_t           calc;
  logic                blk = 1'b0;
  pts_cond_t           cond;
  logic                start;
  logic                trip;
  logic                blocked;
  int                  n_mismatch = 0;
  int                  n_tests = 0;
  int                  cyc = 0;

  // Clock
  initial begin
    forever #10 clk = ~clk;
  end

  pts_meas_src pts_meas_src_inst (
    .clk_in(clk), .meas_req_in(mreq), .calc_req_in(creq),
    .meas_out(meas), .calc_out(calc));
  pts_stage #(.STEP_CYCLES(SC), .WIN_CYCLES(40)) pts_stage_inst (
    .CLK_IN(clk), .NRST_IN(nrst), .BUS_IN(req), .RDATA_OUT(rdata),
    .MEAS_IN(meas), .CALC_IN(calc), .BLOCK_IN(blk), .COND_OUT(cond),
    .START_OUT(start), .TRIP_OUT(trip), .BLOCKED_OUT(blocked));

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rst(input pts_word_t b);
    @(posedge clk);
    nrst <= 1'b0;
    blk <= 1'b0;
    mreq <= {32'h0, 32'h0, b};
    creq <= 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [7:0] ca(input int n, input logic [2:0] f);
    return {CH_BASE + 3'(n), f, 2'b00};
  endfunction
  // Sets channel 0 and reads its fulfilled flag
  task automatic lvl(input pts_word_t v, input logic e, input string m);
    logic [31:0] d;
    @(posedge clk);
    mreq[0] <= v;
    repeat (4) @(posedge clk);
    rd(A_STAT, d);
    chk({31'h0, d[2]}, {31'h0, e}, m);
  endtask

  task automatic t_defaults();
    logic [31:0] d;
    logic [7:0]  a [11];
    logic [31:0] e [11];
    a = '{A_CTRL, A_OPDLY, A_RELDLY, A_EXPECT, ca(0, F_MODE), ca(0, F_MULT),
          ca(0, F_PLO), ca(0, F_HYST), ca(1, F_HYST), ca(2, F_HYST), 8'hFC};
    e = '{32'h1, 32'h8, 32'hC, 32'h28, 32'h0, 32'h1_0000, 32'h64,
          32'h7530, 32'h7530, 32'h7530, 32'h0};
    for (int i = 0; i < 11; i++) begin
      rd(a[i], d);
      chk(d, e[i], "reset value");
    end
    $display("t_defaults done");
  endtask
  task automatic t_over();
    logic [31:0] d;
    int n = 0;
    rst(32'h0000_00C8);
    while (!start && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(start, 1'b1, "start on over");
    rd(A_REMAIN, d);
    chk(d > 0 && d <= 32'h28, 1'b1, "time left");
    n = 2;
    while (!trip && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, OPS * SC + 1, "operate delay");
    @(posedge clk);
    mreq[0] <= 32'h0;
    n = 0;
    while (start && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n >= RLS * SC + 1 && n <= RLS * SC + 4, 1'b1, "release");
    $display("t_over done");
  endtask
  task automatic t_levels();
    rst(32'h0);
    wr(ca(0, F_MODE), 32'h1);
    lvl(32'hFFFF_FF9E, 1'b0, "abs edge");
    lvl(32'hFFFF_FF38, 1'b1, "abs over");
    lvl(32'hFFFF_FF9E, 1'b1, "hyst hold");
    lvl(32'hFFFF_FFA0, 1'b0, "hyst clear");
    wr(ca(0, F_MODE), 32'h2);
    wr(ca(0, F_BLIM), 32'h32);
    lvl(32'h0000_00C8, 1'b0, "under high");
    lvl(32'h0000_003C, 1'b1, "under");
    lvl(32'h0000_0028, 1'b0, "under blocked");
    wr(ca(0, F_MODE), 32'h3);
    wr(ca(0, F_BLIM), 32'hFFFF_FC18);
    lvl(32'hFFFF_FFC4, 1'b1, "abs under");
    lvl(32'hFFFF_FF6A, 1'b0, "abs under high");
    $display("t_levels done");
  endtask
  task automatic t_block();
    rst(32'h0);
    @(posedge clk);
    blk <= 1'b1;
    mreq[0] <= 32'h0000_00C8;
    repeat (6) @(posedge clk);
    #1 chk(cond, ST_BLOCKED, "blocked");
    repeat (100) @(posedge clk);
    #1 chk(trip, 1'b0, "trip while blocked");
    @(posedge clk);
    blk <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk(start, 1'b1, "start after unblock");
    @(posedge clk);
    blk <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(blocked, 1'b1, "start blocked");
    $display("t_block done");
  endtask
  task automatic t_scale();
    logic [31:0] d;
    rst(32'h0);
    @(posedge clk);
    mreq[1] <= 32'h0000_00C8;
    repeat (10) @(posedge clk);
    #1 chk(start, 1'b0, "channel off");
    wr(A_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    #1 chk(start, 1'b1, "channel on");
    wr(ca(0, F_MULT), 32'h0002_0000);
    mreq[0] <= 32'h0000_0096;
    creq <= 32'h0000_0032;
    repeat (300) @(posedge clk);
    rd(ca(0, F_SCALED), d);
    chk(d, 32'h0000_012C, "scaled");
    rd(ca(0, F_RATIO), d);
    chk(d, 32'h0000_7530, "ratio 0");
    rd(ca(1, F_RATIO), d);
    chk(d, 32'h0000_4E20, "ratio 1");
    rd(A_CRATIO, d);
    chk(d, 32'h0000_1388, "calc ratio");
    $display("t_scale done");
  endtask
  task automatic t_delta();
    int n;
    for (int m = 4; m < 8; m++) begin
      for (int f = 0; f < 2; f++) begin
        rst(32'h0000_03E8);
        wr(ca(0, F_MODE), 32'(m));
        repeat (160) @(posedge clk);
        mreq[0] <= f ? 32'h0000_0320 : 32'h0000_04B0;
        n = 0;
        while (!start && n < 60) begin
          @(posedge clk);
          #1 n++;
        end
        chk(start, f == 0 || m % 2 == 1, "change");
      end
    end
    $display("t_delta done");
  endtask

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    rst(32'h0);
    t_defaults();
    t_over();
    t_levels();
    t_block();
    t_scale();
    t_delta();
    give_verdict();
  end
endmodule
